// ---- rtl/bpr_pin_router.sv ----
// Radio host pin routing: UART, wake, audio port and power enables
`timescale 1ns/1ps
module bpr_pin_router (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // Software configuration
    input  wire logic                     routeAudioReq,
    input  wire logic                     audioMasterReq,
    input  wire logic                     gpio0WlanWakeSel,
    // Core side
    input  wire bpr_pkg::bpr_uart_core_t  uartCore,
    input  wire bpr_pkg::bpr_audio_core_t audioCore,
    input  wire logic                     devWakeGpioOut,
    input  wire logic                     devWakeGpioOeN,
    input  wire logic                     hostWakeOut,
    input  wire logic                     wlanWakeEvent,
    input  wire logic                     gpio0Out,
    input  wire logic                     gpio0OeN,
    output logic                          uartRxData,
    output logic                          uartSendAllowed,
    output logic                          audioRxData,
    output logic                          audioBitClkIn,
    output logic                          audioFrameSyncIn,
    output logic                          devWakeIn,
    output logic                          gpio0In,
    output logic                          routeAudioActive,
    output logic                          inbandSleep,
    output logic                          wlanResetActive,
    output logic                          radioResetActive,
    // Pins
    input  wire logic                     hci_send_permit_n_i,
    input  wire logic                     hci_serial_in_i,
    input  wire logic                     radio_wake_from_host_i,
    input  wire logic                     radio_wake_to_host_i,
    input  wire logic                     hci_receive_permit_n_i,
    input  wire logic                     gpio0_i,
    input  wire logic                     wlan_power_enable,
    input  wire logic                     radio_power_enable,
    output logic                          hci_serial_out,
    output bpr_pkg::bpr_pin_drive_t       hciReceivePermitPin,
    output bpr_pkg::bpr_pin_drive_t       hciSendPermitPin,
    output bpr_pkg::bpr_pin_drive_t       radioWakeToHostPin,
    output bpr_pkg::bpr_pin_drive_t       radioWakeFromHostPin,
    output bpr_pkg::bpr_pin_drive_t       gpio0Pin
);
    localparam int NSYNC = 8;

    logic [NSYNC-1:0] pinsRaw;
    logic [NSYNC-1:0] pinsSync;

    // All pin inputs cross into the clock domain before use
    assign pinsRaw = {hci_send_permit_n_i, hci_serial_in_i, radio_wake_from_host_i,
                      radio_wake_to_host_i, hci_receive_permit_n_i, gpio0_i,
                      wlan_power_enable, radio_power_enable};

    bpr_sync #(
        .WIDTH(NSYNC)
    ) u_sync (
        .clk    (clk),
        .sys_rst(sys_rst),
        .async_i(pinsRaw),
        .sync_o (pinsSync)
    );

    logic sendPermitS;
    logic serialInS;
    logic wakeFromHostS;
    logic wakeToHostS;
    logic recvPermitS;
    logic gpio0S;
    logic wlanEnS;
    logic radioEnS;

    assign {sendPermitS, serialInS, wakeFromHostS, wakeToHostS,
            recvPermitS, gpio0S, wlanEnS, radioEnS} = pinsSync;

    bpr_pkg::bpr_route_t route_q;
    bpr_pkg::bpr_route_t route_d;
    logic                master_q;
    logic                master_d;

    // Route machine; leaving or returning to UART waits for both ports to be idle, except when radio power drops
    always_comb begin
        route_d  = route_q;
        master_d = master_q;
        case (route_q)
            bpr_pkg::ROUTE_UART: begin
                if (routeAudioReq && uartCore.idle && audioCore.idle) begin
                    route_d  = bpr_pkg::ROUTE_AUDIO;
                    master_d = audioMasterReq;
                end
            end
            bpr_pkg::ROUTE_AUDIO: begin
                if (!routeAudioReq) begin
                    route_d = bpr_pkg::ROUTE_DRAIN;
                end else if (audioCore.idle) begin
                    master_d = audioMasterReq;
                end
            end
            bpr_pkg::ROUTE_DRAIN: begin
                // Hold pins until the audio frame in flight ends and the UART core is idle
                if (routeAudioReq) begin
                    route_d = bpr_pkg::ROUTE_AUDIO;
                end else if (uartCore.idle && audioCore.idle) begin
                    route_d = bpr_pkg::ROUTE_UART;
                end
            end
            default: begin
                route_d = bpr_pkg::ROUTE_UART;
            end
        endcase
        if (!radioEnS) begin
            route_d  = bpr_pkg::ROUTE_UART;
            master_d = bpr_pkg::MASTER_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            route_q  <= bpr_pkg::ROUTE_UART;
            master_q <= bpr_pkg::MASTER_RESET;
        end else begin
            route_q  <= route_d;
            master_q <= master_d;
        end
    end

    logic routed;
    assign routed = (route_q != bpr_pkg::ROUTE_UART);

    // Pin drive computed combinationally, then registered
    logic                    serialOut_d;
    bpr_pkg::bpr_pin_drive_t recvPin_d;
    bpr_pkg::bpr_pin_drive_t sendPin_d;
    bpr_pkg::bpr_pin_drive_t hostWakePin_d;
    bpr_pkg::bpr_pin_drive_t devWakePin_d;
    bpr_pkg::bpr_pin_drive_t gpio0Pin_d;
    logic                    serialOut_q;
    bpr_pkg::bpr_pin_drive_t recvPin_q;
    bpr_pkg::bpr_pin_drive_t sendPin_q;
    bpr_pkg::bpr_pin_drive_t hostWakePin_q;
    bpr_pkg::bpr_pin_drive_t devWakePin_q;
    bpr_pkg::bpr_pin_drive_t gpio0Pin_q;

    always_comb begin
        serialOut_d = uartCore.serialOut;
        // UART mode: permit driven low when receiver can accept
        recvPin_d   = '{out: !uartCore.canReceive, oeN: 1'b0};
        sendPin_d   = '{out: 1'b1, oeN: 1'b1};
        hostWakePin_d = '{out: hostWakeOut, oeN: 1'b0};
        devWakePin_d  = '{out: devWakeGpioOut, oeN: devWakeGpioOeN};
        if (routed) begin
            // Bit clock and sync only driven as master
            recvPin_d     = '{out: audioCore.bitClk, oeN: !master_q};
            sendPin_d     = '{out: audioCore.dataOut, oeN: 1'b0};
            hostWakePin_d = '{out: audioCore.frameSync, oeN: !master_q};
            devWakePin_d  = '{out: 1'b0, oeN: 1'b1};
        end
        if (gpio0WlanWakeSel) begin
            gpio0Pin_d = '{out: wlanWakeEvent, oeN: 1'b0};
        end else begin
            gpio0Pin_d = '{out: gpio0Out, oeN: gpio0OeN};
        end
        if (!radioEnS) begin
            serialOut_d   = 1'b1;
            recvPin_d     = '{out: 1'b1, oeN: 1'b1};
            sendPin_d     = '{out: 1'b1, oeN: 1'b1};
            hostWakePin_d = '{out: bpr_pkg::WAKE_IDLE, oeN: 1'b1};
            devWakePin_d  = '{out: 1'b0, oeN: 1'b1};
        end
        if (!wlanEnS) begin
            gpio0Pin_d = '{out: 1'b0, oeN: 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serialOut_q   <= 1'b1;
            recvPin_q     <= '{out: 1'b1, oeN: 1'b1};
            sendPin_q     <= '{out: 1'b1, oeN: 1'b1};
            hostWakePin_q <= '{out: 1'b0, oeN: 1'b1};
            devWakePin_q  <= '{out: 1'b0, oeN: 1'b1};
            gpio0Pin_q    <= '{out: 1'b0, oeN: 1'b1};
        end else begin
            serialOut_q   <= serialOut_d;
            recvPin_q     <= recvPin_d;
            sendPin_q     <= sendPin_d;
            hostWakePin_q <= hostWakePin_d;
            devWakePin_q  <= devWakePin_d;
            gpio0Pin_q    <= gpio0Pin_d;
        end
    end

    assign hci_serial_out       = serialOut_q;
    assign hciReceivePermitPin  = recvPin_q;
    assign hciSendPermitPin     = sendPin_q;
    assign radioWakeToHostPin   = hostWakePin_q;
    assign radioWakeFromHostPin = devWakePin_q;
    assign gpio0Pin             = gpio0Pin_q;

    // Core-facing inputs; flow control is forced off while routed
    always_comb begin
        uartRxData       = serialInS;
        uartSendAllowed  = !routed && !sendPermitS && radioEnS;
        audioRxData      = routed ? wakeFromHostS : 1'b0;
        audioBitClkIn    = (routed && !master_q) ? recvPermitS : 1'b0;
        audioFrameSyncIn = (routed && !master_q) ? wakeToHostS : 1'b0;
        devWakeIn        = routed ? 1'b0 : wakeFromHostS;
        gpio0In          = gpio0S;
        routeAudioActive = (route_q == bpr_pkg::ROUTE_AUDIO);
        // Without wake pins sleep must travel as three-wire link frames
        inbandSleep      = routed;
        wlanResetActive  = !wlanEnS;
        radioResetActive = !radioEnS;
    end
endmodule : bpr_pin_router

// ---- rtl/bpr_pkg.sv ----
// Package of constants and carrier types for the radio host pin routing block
package bpr_pkg;

    localparam int  SYNC_STAGES   = 2;
    localparam bit  ROUTE_RESET   = 1'b0;
    localparam bit  MASTER_RESET  = 1'b0;
    localparam bit  WAKE_IDLE     = 1'b0;

    // Route states, one-hot
    typedef enum logic [2:0] {
        ROUTE_UART  = 3'b001,
        ROUTE_DRAIN = 3'b010,
        ROUTE_AUDIO = 3'b100
    } bpr_route_t;

    // Internal audio port as seen by the core
    typedef struct packed {
        logic bitClk;
        logic frameSync;
        logic dataOut;
        logic master;
        logic idle;
    } bpr_audio_core_t;

    // Internal UART core signals
    typedef struct packed {
        logic serialOut;
        logic canReceive;
        logic idle;
    } bpr_uart_core_t;

    // One bidirectional pin: output enable low means driven
    typedef struct packed {
        logic out;
        logic oeN;
    } bpr_pin_drive_t;

endpackage : bpr_pkg

// ---- rtl/bpr_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bpr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    // Refused at elaboration: a zero-width crossing has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("bpr_sync WIDTH must be at least one");
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= async_i;
            stage2_q <= stage1_q;
        end
    end

    assign sync_o = stage2_q;
endmodule : bpr_sync

// ---- verif/bpr_host_model.sv ----
// Host processor model on the far side of the serial, permit and wake pins
`timescale 1ns/1ps
module bpr_host_model (
    input  wire logic clk,
    input  wire logic ready,
    input  wire logic txBit,
    input  wire logic wakeBit,
    input  wire logic clkOn,
    output logic      permitN = 1'h1,
    output logic      serialIn = 1'h1,
    output logic      wakeLine = 1'h0,
    output logic      bitClk = 1'h0
);
    // Slave clock stands still outside frames
    always @(posedge clk) begin
        permitN  <= !ready;
        serialIn <= txBit;
        wakeLine <= wakeBit;
        bitClk   <= clkOn & !bitClk;
    end
endmodule : bpr_host_model

// ---- verif/bpr_pin_router_monitor.sv ----
// Assertion checker watching the ports of the radio host pin router
`timescale 1ns/1ps
module bpr_pin_router_monitor (
    input wire logic                     clk,
    input wire logic                     sys_rst,
    input wire bpr_pkg::bpr_uart_core_t  uartCore,
    input wire bpr_pkg::bpr_audio_core_t audioCore,
    input wire logic                     hci_send_permit_n_i,
    input wire logic                     hci_serial_in_i,
    input wire logic                     uartRxData,
    input wire logic                     uartSendAllowed,
    input wire logic                     routeAudioActive,
    input wire logic                     inbandSleep,
    input wire logic                     radioResetActive,
    input wire logic                     hci_serial_out,
    input wire bpr_pkg::bpr_pin_drive_t  hciReceivePermitPin,
    input wire bpr_pkg::bpr_pin_drive_t  hciSendPermitPin,
    input wire bpr_pkg::bpr_pin_drive_t  radioWakeToHostPin
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_uart;
        (!inbandSleep && !radioResetActive) ##1 (!inbandSleep && !radioResetActive);
    endsequence
    sequence s_audio;
        (routeAudioActive && !radioResetActive) ##1 (routeAudioActive && !radioResetActive);
    endsequence
    a_reset_pins_idle: assert property ($fell(sys_rst) |-> hci_serial_out &&
        hciReceivePermitPin.oeN && hciSendPermitPin.oeN && radioWakeToHostPin.oeN)
        else $error("pins not idle after reset");
    a_send_permit_gate: assert property (hci_send_permit_n_i [*4] |-> !uartSendAllowed)
        else $error("send allowed while permit high");
    a_rx_data_follow: assert property ($stable(hci_serial_in_i) [*3] |->
        uartRxData == hci_serial_in_i) else $error("serial in not passed");
    a_rx_permit_drive: assert property (s_uart |-> !hciReceivePermitPin.oeN &&
        hciReceivePermitPin.out == !$past(uartCore.canReceive))
        else $error("receive permit pin wrong");
    a_tx_serial_out: assert property (!radioResetActive [*2] |->
        hci_serial_out == $past(uartCore.serialOut)) else $error("serial out wrong");
    a_audio_out_map: assert property (s_audio |-> !hciSendPermitPin.oeN &&
        hciSendPermitPin.out == $past(audioCore.dataOut)) else $error("audio out not routed");
    a_audio_clk_dir: assert property (s_audio |->
        hciReceivePermitPin.oeN == radioWakeToHostPin.oeN &&
        (hciReceivePermitPin.oeN || hciReceivePermitPin.out == $past(audioCore.bitClk)))
        else $error("audio clock direction wrong");
    a_route_when_idle: assert property ($rose(inbandSleep) |->
        $past(uartCore.idle && audioCore.idle)) else $error("route changed while busy");
    a_release_when_idle: assert property ($fell(inbandSleep) && !$past(radioResetActive) |->
        $past(uartCore.idle && audioCore.idle)) else $error("route released while busy");
endmodule : bpr_pin_router_monitor

// ---- verif/tb_bpr_pin_router.sv ----
// Self-checking testbench for the radio host pin router
`timescale 1ns/1ps
module tb_bpr_pin_router;
    logic clk = 1'h0, sys_rst = 1'h1, routeAudioReq = 1'h0, audioMasterReq = 1'h1;
    logic gpio0WlanWakeSel = 1'h0, devWakeGpioOut = 1'h0, devWakeGpioOeN = 1'h1;
    logic hostWakeOut = 1'h0, wlanWakeEvent = 1'h0, gpio0Out = 1'h0, gpio0OeN = 1'h1;
    logic wlan_power_enable = 1'h1, radio_power_enable = 1'h1, ready = 1'h0, txBit = 1'h1;
    logic wakeBit = 1'h0, clkOn = 1'h0, hostPermitN, hostWake, hostClk, b;
    logic uartRxData, uartSendAllowed, audioRxData, audioBitClkIn, audioFrameSyncIn, devWakeIn;
    logic gpio0In, routeAudioActive, inbandSleep, wlanResetActive, radioResetActive;
    logic hci_serial_out, hci_send_permit_n_i, hci_serial_in_i, radio_wake_from_host_i;
    logic radio_wake_to_host_i, hci_receive_permit_n_i, gpio0_i;
    int   fails = 0, num_checks = 0;
    bpr_pkg::bpr_uart_core_t  uartCore = 3'h7;
    bpr_pkg::bpr_audio_core_t audioCore = 5'h01;
    bpr_pkg::bpr_pin_drive_t  hciReceivePermitPin, hciSendPermitPin, radioWakeToHostPin;
    bpr_pkg::bpr_pin_drive_t  radioWakeFromHostPin, gpio0Pin;
    always #4 clk = ~clk;
    // A released general pin shows the inverse of the out value it holds while released
    assign hci_send_permit_n_i = hciSendPermitPin.oeN ? hostPermitN : hciSendPermitPin.out;
    assign radio_wake_from_host_i = radioWakeFromHostPin.oeN ? hostWake : radioWakeFromHostPin.out;
    assign hci_receive_permit_n_i = hciReceivePermitPin.oeN ? hostClk : hciReceivePermitPin.out;
    assign radio_wake_to_host_i = radioWakeToHostPin.oeN ? hostClk : radioWakeToHostPin.out;
    assign gpio0_i = gpio0Pin.oeN ? ~gpio0Pin.out : gpio0Pin.out;
    bpr_pin_router dut_u (.*);
    bpr_host_model host_u (.clk(clk), .ready(ready), .txBit(txBit), .wakeBit(wakeBit),
        .clkOn(clkOn), .permitN(hostPermitN), .serialIn(hci_serial_in_i),
        .wakeLine(hostWake), .bitClk(hostClk));
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task ck(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'h1) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : ck
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task waitRoute(input logic v);
        for (int n = 0; n < 20 && routeAudioActive !== v; n++) step(1);
        ck(routeAudioActive === v, "route state");
        if (routeAudioActive !== v) report_and_stop();
    endtask : waitRoute
    task t_uart;
        ready = 1'h1;
        step(4);
        ck(uartSendAllowed === 1'h1, "send allowed");
        ready = 1'h0;
        step(4);
        ck(uartSendAllowed === 1'h0, "send blocked");
        for (int i = 0; i < 2; i++) begin
            b = i[0];
            txBit = b;
            uartCore.serialOut = b;
            uartCore.canReceive = b;
            step(4);
            ck(uartRxData === b && hci_serial_out === b, "serial data");
            ck(hciReceivePermitPin === {~b, 1'h0}, "receive permit");
        end
        hostWakeOut = 1'h1;
        devWakeGpioOut = 1'h1;
        devWakeGpioOeN = 1'h0;
        step(4);
        ck(radioWakeToHostPin === 2'h2 && radioWakeFromHostPin === 2'h2, "wake pins");
        ck(devWakeIn === 1'h1 && gpio0In === 1'h1, "wake and gpio inputs");
        hostWakeOut = 1'h0;
        devWakeGpioOut = 1'h0;
        devWakeGpioOeN = 1'h1;
        ready = 1'h1;
        $display("uart test done");
    endtask : t_uart
    task t_route;
        audioCore.idle = 1'h0;
        routeAudioReq = 1'h1;
        step(6);
        ck(inbandSleep === 1'h0, "route waits for idle");
        audioCore.idle = 1'h1;
        waitRoute(1'h1);
        for (int i = 0; i < 2; i++) begin
            b = i[0];
            audioCore.bitClk = b;
            audioCore.dataOut = ~b;
            audioCore.frameSync = b;
            wakeBit = b;
            uartCore.serialOut = ~b;
            step(4);
            ck(hciReceivePermitPin === {b, 1'h0} && radioWakeToHostPin === {b, 1'h0}, "clk");
            ck(hciSendPermitPin === {~b, 1'h0} && audioRxData === b, "audio data");
            ck(hci_serial_out === ~b && inbandSleep === 1'h1, "three wire");
        end
        routeAudioReq = 1'h0;
        waitRoute(1'h0);
        audioMasterReq = 1'h0;
        routeAudioReq = 1'h1;
        waitRoute(1'h1);
        clkOn = 1'h1;
        step(4);
        b = audioBitClkIn;
        step(1);
        ck(hciReceivePermitPin.oeN === 1'h1 && audioBitClkIn === ~b, "slave clock");
        ck(radioWakeToHostPin.oeN === 1'h1 && audioFrameSyncIn === ~b, "slave sync");
        clkOn = 1'h0;
        routeAudioReq = 1'h0;
        waitRoute(1'h0);
        audioMasterReq = 1'h1;
        $display("route test done");
    endtask : t_route
    task t_power;
        wlan_power_enable = 1'h0;
        step(4);
        ck(wlanResetActive === 1'h1, "wlan held");
        wlan_power_enable = 1'h1;
        // Enable crosses two flops before the reset flag drops
        step(3);
        routeAudioReq = 1'h1;
        waitRoute(1'h1);
        ck(wlanResetActive === 1'h0, "wlan released");
        radio_power_enable = 1'h0;
        step(5);
        ck(radioResetActive === 1'h1 && routeAudioActive === 1'h0, "radio held");
        routeAudioReq = 1'h0;
        radio_power_enable = 1'h1;
        step(5);
        ck(radioResetActive === 1'h0, "radio released");
        gpio0WlanWakeSel = 1'h1;
        for (int i = 0; i < 2; i++) begin
            wlanWakeEvent = i[0];
            step(2);
            ck(gpio0Pin === {i[0], 1'h0}, "wlan wake out");
        end
        $display("power and wake test done");
    endtask : t_power
    initial begin
        for (int r = 0; r < 2; r++) begin
            sys_rst = 1'h1;
            step(4);
            sys_rst = 1'h0;
            ck(hci_serial_out === 1'h1 && radioWakeToHostPin.oeN === 1'h1, "reset pins");
            t_uart();
        end
        t_route();
        t_power();
        report_and_stop();
    end
endmodule : tb_bpr_pin_router
bind bpr_pin_router bpr_pin_router_monitor mon_u (.*);
